//--- ddr2_cmd_pkg.sv
package ddr2_cmd_pkg;
  localparam int BANK_COUNT = 4;
  localparam int BA_W = 2;
  localparam int ADDR_W = 13;
  localparam int COL_W = 9;
  localparam int AUTO_PRE_BIT = 10;
  localparam int BURST_BEATS = 4;
  localparam int BEAT_W = 3;
  localparam int T_RP_NS = 15;
  localparam int SYS_PERIOD_NS = 20;
  localparam int RP_CYCLES = (T_RP_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int RP_W = 4;
  // Synchroniser bit positions
  localparam int PIN_W = 22;
  localparam int POS_CK = 0;
  localparam int POS_CK_N = 1;
  localparam int POS_CKE = 2;
  localparam int POS_CS_N = 3;
  localparam int POS_RAS_N = 4;
  localparam int POS_CAS_N = 5;
  localparam int POS_WE_N = 6;
  localparam int POS_BA = 7;
  localparam int POS_ADDR = 9;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_ROW_OPEN,
    CMD_BANK_CLOSE,
    CMD_READ,
    CMD_WRITE,
    CMD_REFRESH,
    CMD_OTHER
  } cmd_kind_t;

  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SUSPEND,
    PWR_DOWN,
    PWR_SELF
  } pwr_state_t;
endpackage : ddr2_cmd_pkg

//--- bank_cmd_if.sv
`timescale 1ns/1ps
interface bank_cmd_if;
  import ddr2_cmd_pkg::*;
  logic valid;
  cmd_kind_t kind;
  logic [BA_W-1:0] bank;
  logic auto_pre;
  logic burst_done;
  logic [BANK_COUNT-1:0] bank_open;
  logic all_idle;
  modport decoder (output valid, output kind, output bank, output auto_pre,
                   output burst_done, input bank_open, input all_idle);
  modport tracker (input valid, input kind, input bank, input auto_pre,
                   input burst_done, output bank_open, output all_idle);
endinterface : bank_cmd_if

//--- bank_tracker.sv
`timescale 1ns/1ps
module bank_tracker
  import ddr2_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  bank_cmd_if.tracker cmd
);
  function automatic logic [BANK_COUNT-1:0] bank_hot(input logic [BA_W-1:0] b);
    bank_hot = '0;
    bank_hot[b] = 1'b1;
  endfunction : bank_hot

  logic [BANK_COUNT-1:0] open_flag;
  logic [BANK_COUNT-1:0] ap_pending;
  logic [RP_W-1:0] rp_timer [BANK_COUNT];
  logic [BANK_COUNT-1:0] rp_busy;

  wire [BANK_COUNT-1:0] sel = bank_hot(cmd.bank);
  wire do_open = cmd.valid && cmd.kind == CMD_ROW_OPEN;
  wire do_close = cmd.valid && cmd.kind == CMD_BANK_CLOSE;
  wire do_col = cmd.valid && (cmd.kind == CMD_READ || cmd.kind == CMD_WRITE);

  assign cmd.bank_open = open_flag;
  assign cmd.all_idle = ~|open_flag && ~|rp_busy;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      open_flag <= '0;
      ap_pending <= '0;
      for (int i = 0; i < BANK_COUNT; i++) begin
        rp_timer[i] <= '0;
      end
    end else begin
      for (int i = 0; i < BANK_COUNT; i++) begin
        if (do_open && sel[i]) begin
          open_flag[i] <= 1'b1;
        end else if ((do_close && sel[i]) || (cmd.burst_done && ap_pending[i])) begin
          rp_timer[i] <= RP_W'(RP_CYCLES);
        end else if (rp_timer[i] != '0) begin
          rp_timer[i] <= rp_timer[i] - 1'b1;
          if (rp_timer[i] == RP_W'(1)) begin
            open_flag[i] <= 1'b0;
          end
        end
        if (do_col && sel[i] && cmd.auto_pre) begin
          ap_pending[i] <= 1'b1;
        end else if (cmd.burst_done) begin
          ap_pending[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < BANK_COUNT; i++) begin
      rp_busy[i] = rp_timer[i] != '0;
    end
  end
endmodule : bank_tracker

//--- ddr2_command_input_decode.sv
`timescale 1ns/1ps
module ddr2_command_input_decode
  import ddr2_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ck,
  input wire logic ck_n,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  output logic cmd_valid,
  output cmd_kind_t cmd_kind,
  output logic [BA_W-1:0] cmd_bank,
  output logic [ADDR_W-1:0] row_addr,
  output logic [COL_W-1:0] col_addr,
  output logic auto_precharge,
  output logic [BANK_COUNT-1:0] bank_open,
  output logic clock_suspended,
  output logic power_down,
  output logic self_refresh,
  output logic read_beat,
  output logic [BEAT_W-1:0] beat_index
);
  bank_cmd_if link ();

  // Three-stage synchroniser, level accepted once stages two and three agree
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] filt;
  logic ck_prev;

  wire [PIN_W-1:0] pins_now = {addr, ba, we_n, cas_n, ras_n, cs_n, cke, ck_n, ck};
  wire [PIN_W-1:0] next_filt = (sync2 & sync3) | (filt & (sync2 | sync3));

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
      ck_prev <= 1'b0;
    end else begin
      sync1 <= pins_now;
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= next_filt;
      ck_prev <= filt[POS_CK];
    end
  end

  // Filtered pin levels
  wire f_ck = filt[POS_CK];
  wire f_ck_n = filt[POS_CK_N];
  wire f_cke = filt[POS_CKE];
  wire f_cs_n = filt[POS_CS_N];
  wire f_ras_n = filt[POS_RAS_N];
  wire f_cas_n = filt[POS_CAS_N];
  wire f_we_n = filt[POS_WE_N];
  wire [BA_W-1:0] f_ba = filt[POS_BA +: BA_W];
  wire [ADDR_W-1:0] f_addr = filt[POS_ADDR +: ADDR_W];

  // Crossing detection: rising on the sampled clock pair, falling on ck alone
  wire rise_x = f_ck && !ck_prev && !f_ck_n;
  wire fall_x = !f_ck && ck_prev;

  // Power and clock-suspend state
  pwr_state_t pwr_state;
  pwr_state_t next_pwr;
  wire running = pwr_state == PWR_RUN;

  // Command decoding from the strobe levels
  wire sel_low = !f_cs_n;
  wire dec_open = sel_low && !f_ras_n && f_cas_n && f_we_n;
  wire dec_close = sel_low && !f_ras_n && f_cas_n && !f_we_n;
  wire dec_col = sel_low && f_ras_n && !f_cas_n;
  wire dec_read = dec_col && f_we_n;
  wire dec_write = dec_col && !f_we_n;
  wire dec_refresh = sel_low && !f_ras_n && !f_cas_n && f_we_n;
  wire dec_other = sel_low && !dec_open && !dec_close && !dec_col && !dec_refresh;
  wire take_cmd = rise_x && running;

  cmd_kind_t dec_kind;
  assign dec_kind = dec_open ? CMD_ROW_OPEN :
                    dec_close ? CMD_BANK_CLOSE :
                    dec_read ? CMD_READ :
                    dec_write ? CMD_WRITE :
                    dec_refresh ? CMD_REFRESH :
                    dec_other ? CMD_OTHER : CMD_NONE;

  wire any_cmd = take_cmd && sel_low;
  wire col_cmd = take_cmd && dec_col;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_valid <= 1'b0;
      cmd_kind <= CMD_NONE;
      cmd_bank <= '0;
    end else begin
      cmd_valid <= any_cmd;
      if (any_cmd) begin
        cmd_kind <= dec_kind;
        cmd_bank <= f_ba;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      row_addr <= '0;
      col_addr <= '0;
      auto_precharge <= 1'b0;
    end else if (take_cmd && dec_open) begin
      row_addr <= f_addr;
    end else if (col_cmd) begin
      col_addr <= f_addr[COL_W-1:0];
      auto_precharge <= f_addr[AUTO_PRE_BIT];
    end
  end

  // Clock enable: sampled at the rising crossing, acts from the next cycle
  always_comb begin
    next_pwr = pwr_state;
    if (rise_x) begin
      if (f_cke) begin
        next_pwr = PWR_RUN;
      end else if (running) begin
        if (link.all_idle && dec_refresh) begin
          next_pwr = PWR_SELF;
        end else if (link.all_idle && !dec_col && !dec_open) begin
          next_pwr = PWR_DOWN;
        end else begin
          next_pwr = PWR_SUSPEND;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pwr_state <= PWR_RUN;
    end else begin
      pwr_state <= next_pwr;
    end
  end

  assign clock_suspended = pwr_state != PWR_RUN;
  assign power_down = pwr_state == PWR_DOWN;
  assign self_refresh = pwr_state == PWR_SELF;

  // Burst beats on both crossings, frozen while suspended
  logic [BEAT_W-1:0] beats_left;
  logic burst_read;
  logic burst_done;
  wire beat_x = (rise_x || fall_x) && running && beats_left != '0;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      beats_left <= '0;
      burst_read <= 1'b0;
      read_beat <= 1'b0;
      beat_index <= '0;
      burst_done <= 1'b0;
    end else begin
      read_beat <= beat_x && burst_read;
      burst_done <= beat_x && beats_left == BEAT_W'(1);
      if (col_cmd) begin
        beats_left <= BEAT_W'(BURST_BEATS);
        burst_read <= dec_read;
      end else if (beat_x) begin
        beats_left <= beats_left - 1'b1;
        beat_index <= BEAT_W'(BURST_BEATS) - beats_left;
      end
    end
  end

  assign link.valid = cmd_valid;
  assign link.kind = cmd_kind;
  assign link.bank = cmd_bank;
  assign link.auto_pre = auto_precharge;
  assign link.burst_done = burst_done;
  assign bank_open = link.bank_open;

  bank_tracker u_tracker (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .cmd(link.tracker)
  );

  // Checks
  default clocking chk_clk @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_live_rise;
    rise_x && running;
  endsequence

  sequence s_cke_drop;
    rise_x && running && !f_cke;
  endsequence

  sequence s_idle_drop;
    s_cke_drop ##0 (link.all_idle && !sel_low);
  endsequence

  a_cmd_on_rise: assert property (cmd_valid |-> $past(rise_x))
    else $error("command reported without a rising crossing");

  a_cs_masks: assert property (rise_x && f_cs_n |=> !cmd_valid)
    else $error("command decoded with chip select high");

  a_row_open_dec: assert property (s_live_rise ##0 dec_open
                                   |=> cmd_valid && cmd_kind == CMD_ROW_OPEN)
    else $error("activate not decoded");

  a_close_dec: assert property (s_live_rise ##0
                                (sel_low && !f_ras_n && f_cas_n && !f_we_n)
                                |=> cmd_valid && cmd_kind == CMD_BANK_CLOSE)
    else $error("precharge not decoded");

  a_col_read: assert property (s_live_rise ##0
                               (sel_low && f_ras_n && !f_cas_n && f_we_n)
                               |=> cmd_valid && cmd_kind == CMD_READ)
    else $error("read not decoded");

  a_col_write: assert property (s_live_rise ##0
                                (sel_low && f_ras_n && !f_cas_n && !f_we_n)
                                |=> cmd_valid && cmd_kind == CMD_WRITE)
    else $error("write not decoded");

  a_bank_route: assert property (cmd_valid && cmd_kind == CMD_ROW_OPEN
                                 |=> bank_open[$past(cmd_bank)])
    else $error("activated bank not open");

  a_row_latch: assert property (s_live_rise ##0 dec_open
                                |=> row_addr == $past(f_addr) && cmd_bank == $past(f_ba))
    else $error("row address not latched");

  a_col_field: assert property (col_cmd |=> col_addr == $past(f_addr[COL_W-1:0])
                                && auto_precharge == $past(f_addr[AUTO_PRE_BIT]))
    else $error("column or auto-precharge not latched");

  a_close_idle: assert property (cmd_valid && cmd_kind == CMD_BANK_CLOSE
                                 |-> ##[1:8] !bank_open[cmd_bank])
    else $error("precharged bank did not return to idle");

  a_suspend_next: assert property (s_cke_drop |=> clock_suspended)
    else $error("clock not suspended after clock enable low");

  a_suspend_freeze: assert property (clock_suspended |=> !read_beat && $stable(beats_left))
    else $error("burst moved while suspended");

  a_idle_pd: assert property (s_idle_drop |=> power_down)
    else $error("idle banks with clock enable low did not power down");

  a_two_beats: assert property (read_beat |-> $past(rise_x || fall_x))
    else $error("read beat not tied to a crossing");

  // Power-state, hold, crossing and burst checks
  sequence s_wake;
    rise_x && !running && f_cke;
  endsequence

  sequence s_refresh_drop;
    s_cke_drop ##0 (link.all_idle && dec_refresh);
  endsequence

  sequence s_busy_drop;
    s_cke_drop ##0 !link.all_idle;
  endsequence

  a_self_entry: assert property (s_refresh_drop |=> self_refresh && !power_down)
    else $error("idle refresh with clock enable low did not enter self-refresh");

  a_busy_suspend: assert property (s_busy_drop
                                   |=> clock_suspended && !power_down && !self_refresh)
    else $error("busy banks entered a low-power mode");

  a_wake_run: assert property (s_wake |=> !clock_suspended)
    else $error("clock enable high did not resume the internal clock");

  a_stay_frozen: assert property (!running && !(rise_x && f_cke)
                                  |=> $stable(pwr_state))
    else $error("suspended state left without clock enable high");

  a_no_cmd_frozen: assert property (!running |=> !cmd_valid)
    else $error("command reported while suspended");

  a_fall_no_cmd: assert property (fall_x |=> !cmd_valid)
    else $error("command taken at a falling crossing");

  a_bank_hold: assert property (!cmd_valid
                                |-> $stable(cmd_bank) && $stable(cmd_kind))
    else $error("bank or kind changed without a command");

  a_row_hold: assert property (!(take_cmd && dec_open) |=> $stable(row_addr))
    else $error("row address changed without an activate");

  a_burst_load: assert property (col_cmd |=> beats_left == BEAT_W'(BURST_BEATS))
    else $error("column access did not load a full burst");

  a_write_quiet: assert property (take_cmd && dec_write |=> !burst_read)
    else $error("write burst marked as read");
endmodule : ddr2_command_input_decode

//--- ddr2_ctrl_model.sv
`timescale 1ns/1ps
module ddr2_ctrl_model
  import ddr2_cmd_pkg::*;
(
  input wire logic sys_clk,
  output logic ck,
  output logic ck_n,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr
);
  initial begin
    ck = 1'b0;
    ck_n = 1'b1;
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = '0;
    addr = '0;
  end
  // One memory clock period; pins change at the fall and hold four cycles each side
  task automatic period(input logic [3:0] c, input logic e, input logic [BA_W-1:0] b,
                        input logic [ADDR_W-1:0] a);
    {cs_n, ras_n, cas_n, we_n} = c;
    cke = e;
    ba = b;
    addr = a;
    repeat (4) @(negedge sys_clk);
    ck = 1'b1;
    ck_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    ck = 1'b0;
    ck_n = 1'b1;
  endtask : period
endmodule : ddr2_ctrl_model

//--- tb.sv
`timescale 1ns/1ps
module tb;
  import ddr2_cmd_pkg::*;
  localparam logic [3:0] ACT = 4'h3, PRE = 4'h2, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] REF = 4'h1, NOP = 4'hf, DES_ACT = 4'hb;
  typedef struct packed {
    logic [3:0] c;
    logic [BA_W-1:0] b;
    logic [ADDR_W-1:0] a;
    logic v;
    cmd_kind_t k;
    logic [BANK_COUNT-1:0] open;
    logic [2:0] beats;
  } row_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ck, ck_n, cke, cs_n, ras_n, cas_n, we_n;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic cmd_valid, auto_precharge, clock_suspended, power_down, self_refresh, read_beat;
  cmd_kind_t cmd_kind;
  logic [BA_W-1:0] cmd_bank;
  logic [ADDR_W-1:0] row_addr;
  logic [COL_W-1:0] col_addr;
  logic [BANK_COUNT-1:0] bank_open;
  logic [BEAT_W-1:0] beat_index;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int nv = 0;
  int nb = 0;
  cmd_kind_t k_seen;
  logic [BA_W-1:0] b_seen;
  row_t rows [8] = '{
    '{ACT, 2'h2, 13'h1abc, 1'b1, CMD_ROW_OPEN, 4'h4, 3'h0},
    '{RD, 2'h2, 13'h0155, 1'b1, CMD_READ, 4'h4, 3'h4},
    '{WR, 2'h2, 13'h04aa, 1'b1, CMD_WRITE, 4'h0, 3'h0},
    '{ACT, 2'h1, 13'h0f0f, 1'b1, CMD_ROW_OPEN, 4'h2, 3'h0},
    '{DES_ACT, 2'h3, 13'h1fff, 1'b0, CMD_ROW_OPEN, 4'h2, 3'h0},
    '{PRE, 2'h1, 13'h0400, 1'b1, CMD_BANK_CLOSE, 4'h0, 3'h0},
    '{REF, 2'h0, 13'h0000, 1'b1, CMD_REFRESH, 4'h0, 3'h0},
    '{4'h7, 2'h1, 13'h0000, 1'b1, CMD_OTHER, 4'h0, 3'h0}};

  always #10 sys_clk = ~sys_clk;

  ddr2_ctrl_model ctrl (.sys_clk(sys_clk), .ck(ck), .ck_n(ck_n), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

  ddr2_command_input_decode DUT (.sys_clk(sys_clk), .nrst(nrst), .ck(ck), .ck_n(ck_n),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_bank(cmd_bank), .row_addr(row_addr),
    .col_addr(col_addr), .auto_precharge(auto_precharge), .bank_open(bank_open),
    .clock_suspended(clock_suspended), .power_down(power_down),
    .self_refresh(self_refresh), .read_beat(read_beat), .beat_index(beat_index));

  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : check

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // Command period followed by an idle period with the same clock enable
  task automatic step(input logic [3:0] c, input logic e, input logic [BA_W-1:0] b,
                      input logic [ADDR_W-1:0] a);
    ctrl.period(c, e, b, a);
    ctrl.period(NOP, e, ~b, ~a);
  endtask : step

  always @(negedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      $display("CHECK FAILED %0t timeout", $time);
      fail_count++;
      stop_test();
    end
    if (cmd_valid === 1'b1) begin
      nv++;
      k_seen = cmd_kind;
      b_seen = cmd_bank;
    end
    if (read_beat === 1'b1) begin
      check(beat_index === 3'(nb % 4), "beat index order");
      nb++;
    end
  end

  initial begin
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    check({cmd_valid, bank_open, clock_suspended, power_down, read_beat} === 8'h00
          && cmd_kind === CMD_NONE, "reset values");
    repeat (5) @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      nv = 0;
      nb = 0;
      step(rows[i].c, 1'b1, rows[i].b, rows[i].a);
      step(NOP, 1'b1, rows[i].b, rows[i].a);
      check(nv === 32'(rows[i].v), "command pulse count");
      check(bank_open === rows[i].open, "bank open state");
      check(nb === 32'(rows[i].beats), "read beat count");
      if (rows[i].v) begin
        check(k_seen === rows[i].k && b_seen === rows[i].b, "kind or bank");
        if (rows[i].c == ACT) check(row_addr === rows[i].a, "row address");
        if (rows[i].c == RD || rows[i].c == WR) begin
          check(col_addr === rows[i].a[8:0], "column address");
          check(auto_precharge === rows[i].a[10], "auto precharge flag");
        end
      end
    end
    nv = 0;
    step(NOP, 1'b0, 2'h0, 13'h0000);
    check(power_down === 1'b1 && clock_suspended === 1'b1, "power-down entry");
    step(ACT, 1'b0, 2'h0, 13'h0123);
    check(nv === 0 && bank_open === 4'h0, "command while suspended");
    step(NOP, 1'b1, 2'h0, 13'h0000);
    check(clock_suspended === 1'b0 && power_down === 1'b0, "power-down exit");
    step(REF, 1'b0, 2'h0, 13'h0000);
    check(self_refresh === 1'b1 && power_down === 1'b0, "self-refresh entry");
    step(NOP, 1'b1, 2'h0, 13'h0000);
    check(self_refresh === 1'b0 && clock_suspended === 1'b0, "self-refresh exit");
    step(ACT, 1'b1, 2'h0, 13'h0aaa);
    step(NOP, 1'b0, 2'h0, 13'h0000);
    check(clock_suspended === 1'b1 && power_down === 1'b0, "suspend with open bank");
    check(bank_open === 4'h1 && row_addr === 13'h0aaa, "frozen state");
    step(NOP, 1'b1, 2'h0, 13'h0000);
    check(clock_suspended === 1'b0, "resume");
    nb = 0;
    ctrl.period(RD, 1'b1, 2'h0, 13'h0033);
    step(NOP, 1'b0, 2'h0, 13'h0000);
    check(nb === 2 && clock_suspended === 1'b1, "burst frozen while suspended");
    step(NOP, 1'b1, 2'h0, 13'h0000);
    ctrl.period(NOP, 1'b1, 2'h0, 13'h0000);
    check(nb === 4 && col_addr === 9'h033, "burst resumed after suspend");
    nrst = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(bank_open === 4'h0 && cmd_kind === CMD_NONE && clock_suspended === 1'b0,
          "mid-run reset");
    nrst = 1'b1;
    repeat (2) @(negedge sys_clk);
    step(ACT, 1'b1, 2'h3, 13'h0001);
    check(bank_open === 4'h8 && row_addr === 13'h0001, "activate after reset");
    stop_test();
  end
endmodule : tb
